// ### hdl/spi_regs_pkg.sv
package spi_regs_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int          ADDR_W     = 8;
  localparam int          IDX_W      = 6;
  localparam int          BYTE_SHIFT = 2;
  localparam int          DATA_W     = 32;
  localparam int          STRB_W     = 4;
  localparam int          DIV_W      = 8;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_CTRL_ONE  = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CTRL_TWO  = 6'h01;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 6'h03;
  localparam logic [IDX_W-1:0] IDX_DATA_HIGH = 6'h04;
  localparam logic [IDX_W-1:0] IDX_DATA_LOW  = 6'h05;
  localparam logic [IDX_W-1:0] IDX_DATA_WORD = 6'h06;

  // ==========================================================================
  // Field positions
  localparam int ST_RX_FULL_BIT   = 7;
  localparam int ST_TX_EMPTY_BIT  = 5;
  localparam int ST_MODE_FAULT_BIT = 4;
  localparam int CR1_IRQ_EN_BIT   = 7;
  localparam int CR1_ENABLE_BIT   = 6;
  localparam int CR1_MASTER_BIT   = 4;
  localparam int CR2_WIDTH_BIT    = 6;
  localparam int CR2_MODE_FAULT_FLAG_EN_BIT  = 4;
  localparam int BYTE_LSB         = 0;
  localparam int HIGH_LSB         = 8;
  localparam int NARROW_MSB       = 7;
  localparam int WIDE_MSB         = 15;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0]  CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0]  CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0]  BYTE_ZERO      = 8'h00;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;
  localparam logic [31:0] BUS_ZERO       = 32'h0000_0000;
  localparam logic [4:0]  BITS_NARROW    = 5'h08;
  localparam logic [4:0]  BITS_WIDE      = 5'h10;
  localparam logic [4:0]  CNT_ZERO       = 5'h00;
  localparam logic [4:0]  CNT_ONE        = 5'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO  = 8'h00;
  localparam logic [DIV_W-1:0] DIV_ONE   = 8'h01;
  localparam logic [DIV_W-1:0] HALF_DIV_DEFAULT = 8'h04;

  // ==========================================================================
  // Types
  typedef enum logic [0:0] {SH_IDLE, SH_RUN} shift_state_e;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } link_in_s;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } link_out_s;

  typedef struct packed {
    logic [7:0]       ctrl_one;
    logic [7:0]       ctrl_two;
    logic             rx_full;
    logic             tx_empty;
    logic             mode_fault;
    logic             arm_rx;
    logic             arm_tx;
    logic             arm_mode_fault_flag;
    logic             high_read;
    logic [15:0]      data_rx;
    logic [15:0]      tx_buf;
    logic [15:0]      hold_word;
    logic             hold_valid;
    logic [15:0]      shreg;
    shift_state_e     phase;
    logic             run_master;
    logic             run_wide;
    logic [4:0]       bit_cnt;
    logic [DIV_W-1:0] div_cnt;
    link_in_s         sync1;
    link_in_s         sync2;
    link_in_s         prev;
    link_out_s        link;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
  } state_s;

endpackage

// ### hdl/spi_status_data_regs.sv
// Notes on behaviour
// - Receive-full set when word reaches data
// - Transmit-empty high while buffer accepts words
// - Mode fault on select low as master
// - Status read then control-one write clears fault
// - Status readable anytime, writes ignored
// - Low byte read after status clears receive-full
// - High byte reads never touch receive-full
// - Wide low-only clearing read drops high byte
// - Low byte write after status clears empty
// - High byte writes never touch transmit-empty
// - Data writes ignored while transmitter full
// - Wide low-only write leaves high byte stale
// - Master starts queued word right after previous
// - Word lands in data when flag clear
// - Second word held until next start
// - Timely service moves held word, flag stays
// - Late service discards held word
// - Bits per transfer follow width select
// - Fault with interrupt enable raises request
`timescale 1ns/1ps
`default_nettype none

module spi_status_data_regs
  #(parameter logic [spi_regs_pkg::DIV_W-1:0] HALF_DIV = spi_regs_pkg::HALF_DIV_DEFAULT)
  (
  // Clock, reset, enable
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               ce,
  // APB slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [spi_regs_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [spi_regs_pkg::DATA_W-1:0]    pwdata,
  input  wire logic [spi_regs_pkg::STRB_W-1:0]    pstrb,
  output logic      [spi_regs_pkg::DATA_W-1:0]    prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // Serial link pins
  input  wire spi_regs_pkg::link_in_s             link_in,
  output spi_regs_pkg::link_out_s                 link_out,
  // Interrupt request
  output logic                                    irq_req
  );

  import spi_regs_pkg::*;

  state_s st_reg;
  state_s st_next;

  assign prdata   = st_reg.prdata;
  assign pready   = st_reg.pready;
  assign pslverr  = st_reg.pslverr;
  assign link_out = st_reg.link;
  assign irq_req  = st_reg.irq;

  // ==========================================================================
  // Decode helpers
  logic [IDX_W-1:0] idx;
  logic             aligned;
  logic             mapped;
  logic             access_done;
  logic             rd_done;
  logic             wr_done;
  logic             lane0;
  logic             lane1;
  logic             wide;
  logic             enabled;
  logic             is_master;
  logic [4:0]       bits_sel;
  logic [7:0]       status_byte;
  logic [31:0]      read_value;

  always_comb begin
    idx         = paddr[ADDR_W-1:BYTE_SHIFT];
    aligned     = (paddr[BYTE_SHIFT-1:0] == 2'b00);
    mapped      = aligned && ((idx == IDX_CTRL_ONE) || (idx == IDX_CTRL_TWO) ||
                  (idx == IDX_STATUS) || (idx == IDX_DATA_HIGH) ||
                  (idx == IDX_DATA_LOW) || (idx == IDX_DATA_WORD));
    access_done = psel && penable && st_reg.pready;
    rd_done     = access_done && !pwrite && mapped;
    wr_done     = access_done && pwrite && mapped;
    lane0       = pstrb[0];
    lane1       = pstrb[1];
    wide        = st_reg.ctrl_two[CR2_WIDTH_BIT];
    enabled     = st_reg.ctrl_one[CR1_ENABLE_BIT];
    is_master   = st_reg.ctrl_one[CR1_MASTER_BIT];
    bits_sel    = wide ? BITS_WIDE : BITS_NARROW;
    status_byte = BYTE_ZERO;
    status_byte[ST_RX_FULL_BIT]    = st_reg.rx_full;
    status_byte[ST_TX_EMPTY_BIT]   = st_reg.tx_empty;
    status_byte[ST_MODE_FAULT_BIT] = st_reg.mode_fault;
    read_value = BUS_ZERO;
    case (idx)
      IDX_CTRL_ONE:  read_value[7:0]  = st_reg.ctrl_one;
      IDX_CTRL_TWO:  read_value[7:0]  = st_reg.ctrl_two;
      IDX_STATUS:    read_value[7:0]  = status_byte;
      IDX_DATA_HIGH: read_value[7:0]  = st_reg.data_rx[WIDE_MSB:HIGH_LSB];
      IDX_DATA_LOW:  read_value[7:0]  = st_reg.data_rx[NARROW_MSB:BYTE_LSB];
      IDX_DATA_WORD: read_value[15:0] = st_reg.data_rx;
      default:       read_value       = BUS_ZERO;
    endcase
  end

  // ==========================================================================
  // Next-state logic
  logic        rx_ev;
  logic [15:0] rx_word;
  logic        start_ev;
  logic        tick;
  logic        sck_rise;
  logic        sck_fall;
  logic        ss_fall;
  logic        din;
  logic [15:0] shifted;
  logic        clear_rx;
  logic        low_write;

  always_comb begin
    st_next   = st_reg;
    rx_ev     = 1'b0;
    rx_word   = WORD_ZERO;
    start_ev  = 1'b0;
    clear_rx  = 1'b0;
    low_write = 1'b0;
    shifted   = WORD_ZERO;

    // Pin synchronisers; only the second stage and its delayed copy for edge detection feed logic
    st_next.sync1 = link_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    sck_rise = st_reg.sync2.sck && !st_reg.prev.sck;
    sck_fall = !st_reg.sync2.sck && st_reg.prev.sck;
    ss_fall  = !st_reg.sync2.ss_n && st_reg.prev.ss_n;
    din      = is_master ? st_reg.sync2.miso : st_reg.sync2.mosi;
    tick     = (st_reg.div_cnt == HALF_DIV - DIV_ONE);

    // ========================================================================
    // APB handshake: no wait state, answer registered at setup
    st_next.pready = 1'b0;
    // Error stands only while ready does
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      st_next.pready  = 1'b1;
      st_next.prdata  = read_value;
      st_next.pslverr = !mapped;
    end

    // ========================================================================
    // Read side effects
    if (rd_done) begin
      case (idx)
        IDX_STATUS: begin
          // Arm only on what software actually saw
          st_next.arm_rx    = st_reg.prdata[ST_RX_FULL_BIT];
          st_next.arm_tx    = st_reg.prdata[ST_TX_EMPTY_BIT];
          st_next.arm_mode_fault_flag  = st_reg.prdata[ST_MODE_FAULT_BIT];
          st_next.high_read = 1'b0;
        end
        IDX_DATA_HIGH: st_next.high_read = 1'b1;
        IDX_DATA_LOW:  clear_rx = st_reg.arm_rx;
        IDX_DATA_WORD: begin
          st_next.high_read = 1'b1;
          clear_rx = st_reg.arm_rx;
        end
        default: ;
      endcase
    end

    if (clear_rx) begin
      st_next.arm_rx = 1'b0;
      if (st_reg.hold_valid) begin
        st_next.data_rx    = st_reg.hold_word;
        st_next.hold_valid = 1'b0;
      end else begin
        st_next.rx_full = 1'b0;
        if (wide && !st_next.high_read) begin
          st_next.data_rx[WIDE_MSB:HIGH_LSB] = BYTE_ZERO;
        end
      end
    end

    // ========================================================================
    // Write side effects; status writes fall through untouched
    if (wr_done) begin
      case (idx)
        IDX_CTRL_ONE: begin
          if (lane0) begin
            st_next.ctrl_one = pwdata[7:0];
            if (st_reg.arm_mode_fault_flag) begin
              st_next.mode_fault = 1'b0;
              st_next.arm_mode_fault_flag   = 1'b0;
            end
          end
        end
        IDX_CTRL_TWO: begin
          if (lane0) begin
            st_next.ctrl_two = pwdata[7:0];
          end
        end
        IDX_DATA_HIGH: begin
          if (lane0 && st_reg.tx_empty) begin
            st_next.tx_buf[WIDE_MSB:HIGH_LSB] = pwdata[7:0];
          end
        end
        IDX_DATA_LOW: begin
          // High byte keeps stale content in wide mode
          if (lane0 && st_reg.tx_empty) begin
            st_next.tx_buf[NARROW_MSB:BYTE_LSB] = pwdata[7:0];
            low_write = 1'b1;
          end
        end
        IDX_DATA_WORD: begin
          if (st_reg.tx_empty) begin
            if (lane1) begin
              st_next.tx_buf[WIDE_MSB:HIGH_LSB] = pwdata[15:8];
            end
            if (lane0) begin
              st_next.tx_buf[NARROW_MSB:BYTE_LSB] = pwdata[7:0];
              low_write = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    if (low_write && st_reg.arm_tx) begin
      st_next.tx_empty = 1'b0;
      st_next.arm_tx   = 1'b0;
    end

    // ========================================================================
    // Shift engine
    case (st_reg.phase)
      SH_IDLE: begin
        st_next.div_cnt = DIV_ZERO;
        // Released select floats the slave output; a finished word
        // would otherwise leave it driving until the next frame
        if (st_reg.sync2.ss_n) begin
          st_next.link.miso_oe = 1'b0;
        end
        if (enabled && is_master && !st_reg.tx_empty) begin
          start_ev           = 1'b1;
          st_next.phase      = SH_RUN;
          st_next.run_master = 1'b1;
          st_next.run_wide   = wide;
          st_next.bit_cnt    = CNT_ZERO;
          st_next.shreg      = st_reg.tx_buf;
          st_next.tx_empty   = 1'b1;
          st_next.link.sck_oe  = 1'b1;
          st_next.link.mosi_oe = 1'b1;
          st_next.link.sck     = 1'b0;
          st_next.link.mosi    = wide ? st_reg.tx_buf[WIDE_MSB] : st_reg.tx_buf[NARROW_MSB];
        end else if (enabled && !is_master && ss_fall) begin
          start_ev           = 1'b1;
          st_next.phase      = SH_RUN;
          st_next.run_master = 1'b0;
          st_next.run_wide   = wide;
          st_next.bit_cnt    = CNT_ZERO;
          st_next.link.miso_oe = 1'b1;
          if (!st_reg.tx_empty) begin
            st_next.shreg    = st_reg.tx_buf;
            st_next.tx_empty = 1'b1;
            st_next.link.miso = wide ? st_reg.tx_buf[WIDE_MSB] : st_reg.tx_buf[NARROW_MSB];
          end else begin
            st_next.link.miso = wide ? st_reg.shreg[WIDE_MSB] : st_reg.shreg[NARROW_MSB];
          end
        end
      end
      SH_RUN: begin
        shifted = {st_reg.shreg[WIDE_MSB-1:BYTE_LSB], din};
        if (st_reg.run_master) begin
          st_next.div_cnt = tick ? DIV_ZERO : st_reg.div_cnt + DIV_ONE;
          if (tick) begin
            if (!st_reg.link.sck) begin
              st_next.link.sck = 1'b1;
              st_next.shreg    = shifted;
              st_next.bit_cnt  = st_reg.bit_cnt + CNT_ONE;
            end else begin
              st_next.link.sck = 1'b0;
              if (st_reg.bit_cnt == (st_reg.run_wide ? BITS_WIDE : BITS_NARROW)) begin
                rx_ev            = 1'b1;
                rx_word          = st_reg.shreg;
                st_next.phase    = SH_IDLE;
                st_next.link.sck_oe  = 1'b0;
                st_next.link.mosi_oe = 1'b0;
              end else begin
                st_next.link.mosi = st_reg.run_wide ? st_reg.shreg[WIDE_MSB]
                                                    : st_reg.shreg[NARROW_MSB];
              end
            end
          end
        end else if (st_reg.sync2.ss_n) begin
          // Deselect mid-word aborts without delivering data
          st_next.phase        = SH_IDLE;
          st_next.link.miso_oe = 1'b0;
        end else if (sck_rise) begin
          st_next.shreg   = shifted;
          st_next.bit_cnt = st_reg.bit_cnt + CNT_ONE;
          if (st_reg.bit_cnt + CNT_ONE == (st_reg.run_wide ? BITS_WIDE : BITS_NARROW)) begin
            rx_ev         = 1'b1;
            rx_word       = shifted;
            st_next.phase = SH_IDLE;
          end
        end else if (sck_fall) begin
          st_next.link.miso = st_reg.run_wide ? st_reg.shreg[WIDE_MSB]
                                              : st_reg.shreg[NARROW_MSB];
        end
      end
      default: st_next.phase = SH_IDLE;
    endcase

    if (!st_reg.run_wide) begin
      rx_word[WIDE_MSB:HIGH_LSB] = BYTE_ZERO;
    end

    // A new transfer invalidates any word still waiting
    if (start_ev) begin
      st_next.hold_valid = 1'b0;
    end

    // Completion wins over a same-cycle clear
    if (rx_ev) begin
      if (!st_next.rx_full) begin
        st_next.data_rx = rx_word;
        st_next.rx_full = 1'b1;
      end else begin
        st_next.hold_word  = rx_word;
        st_next.hold_valid = 1'b1;
      end
    end

    // ========================================================================
    // Mode fault overrides everything, including its own clear
    if (enabled && is_master && st_reg.ctrl_two[CR2_MODE_FAULT_FLAG_EN_BIT] && !st_reg.sync2.ss_n) begin
      st_next.mode_fault = 1'b1;
      st_next.ctrl_one[CR1_MASTER_BIT] = 1'b0;
      st_next.phase        = SH_IDLE;
      st_next.link.sck_oe  = 1'b0;
      st_next.link.mosi_oe = 1'b0;
      st_next.link.miso_oe = 1'b0;
      st_next.link.sck     = 1'b0;
    end

    st_next.irq = st_next.mode_fault && st_next.ctrl_one[CR1_IRQ_EN_BIT];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg            <= '0;
      st_reg.ctrl_one   <= CTRL_ONE_RESET;
      st_reg.ctrl_two   <= CTRL_TWO_RESET;
      st_reg.tx_empty   <= 1'b1;
      st_reg.phase      <= SH_IDLE;
      // Pins rest at idle: clock low, the rest high, so no false edge
      st_reg.sync1      <= '{sck: 1'b0, default: 1'b1};
      st_reg.sync2      <= '{sck: 1'b0, default: 1'b1};
      st_reg.prev       <= '{sck: 1'b0, default: 1'b1};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// ### testbench/spi_link_partner.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Far-side master model, mode 0, MSB first
module spi_link_partner (
  // Pins
  output wire spi_regs_pkg::link_in_s  link_in,
  input  wire spi_regs_pkg::link_out_s link_out
);
  import spi_regs_pkg::*;
  logic sck = 1'b0;
  logic mosi = 1'b1;
  logic ss_n = 1'b1;
  logic noise = 1'b0;

  // Unused input gets a changing pattern, never a settled level
  always #24 noise = ~noise;
  assign link_in = '{sck: sck, mosi: mosi, miso: noise, ss_n: ss_n};

  task automatic xfer(input logic [15:0] tx, input int nb, output logic [15:0] rx);
    rx = 16'h0000;
    #1.3 ss_n = 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      mosi = tx[i];
      #24 rx = {rx[14:0], link_out.miso};
      sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 ss_n = 1'b1;
    // Released line shows the inverse, not a stale bit
    mosi = ~mosi;
  endtask

  task automatic select(input logic lvl);
    #1 ss_n = lvl;
  endtask
endmodule

`default_nettype wire

// ### testbench/spi_status_data_regs_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Port checker
module spi_status_data_regs_checker (
  // Clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  input wire logic                            ce,
  // APB
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [spi_regs_pkg::ADDR_W-1:0] paddr,
  input wire logic [spi_regs_pkg::DATA_W-1:0] prdata,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // Link and interrupt
  input wire spi_regs_pkg::link_in_s          link_in,
  input wire spi_regs_pkg::link_out_s         link_out,
  input wire logic                            irq_req
);
  import spi_regs_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence setup_s;
    ce && psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence

  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_status_wr_ok: assert property (
    setup_s ##1 access_s ##0 (pwrite && paddr[7:2] == IDX_STATUS) |-> !pslverr)
    else $error("status write flagged as error");
  a_unmapped_err: assert property (
    setup_s ##1 access_s ##0 (paddr[7:2] == 6'h02) |-> pslverr)
    else $error("unmapped access not refused");
  a_status_upper: assert property (
    setup_s ##1 access_s ##0 (!pwrite && paddr[7:2] == IDX_STATUS) |-> prdata[31:8] == 24'h0)
    else $error("status upper bits not zero");
  a_select_idle: assert property (link_in.ss_n [*6] |-> !link_out.miso_oe)
    else $error("miso driven while deselected");
  a_fault_quiets: assert property (
    irq_req |-> !link_out.sck_oe && !link_out.mosi_oe)
    else $error("master outputs on during fault");
  a_drive_exclusive: assert property (link_out.miso_oe |-> !link_out.sck_oe)
    else $error("slave and master drive together");
  a_reset_quiet: assert property ($rose(presetn) |-> !pready && !irq_req)
    else $error("outputs active after reset");
endmodule

`default_nettype wire

// ### testbench/spi_status_data_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module spi_status_data_regs_tb;
  import spi_regs_pkg::*;
  logic              pclk, presetn, ce, psel, penable, pwrite;
  logic              pready, pslverr, irq_req, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [STRB_W-1:0] pstrb;
  logic [15:0]       rx;
  link_in_s          link_in;
  link_out_s         link_out;
  int                n_fail = 0;
  int                check_count = 0;

  spi_status_data_regs dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in),
    .link_out(link_out), .irq_req(irq_req));
  spi_link_partner far_u (.link_in(link_in), .link_out(link_out));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // ========================================================================
  // Tasks
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd_chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input string name);
    apb(1'b0, idx, 32'h0);
    check(name, rd, exp);
  endtask

  task wr(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task link(input logic [15:0] tx, input int nb);
    far_u.xfer(tx, nb, rx);
    repeat (4) @(posedge pclk);
  endtask

  task complete_run;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    complete_run();
  end

  // ========================================================================
  // Tests
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    ce = 1'b1;
    pstrb = 4'hF;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(IDX_STATUS, 32'h20, "status");
    rd_chk(IDX_DATA_HIGH, 32'h0, "high");
    rd_chk(IDX_DATA_LOW, 32'h0, "low");
    wr(IDX_STATUS, 32'hFF);
    check("status err", {31'h0, err}, 32'h0);
    rd_chk(IDX_STATUS, 32'h20, "status");
    apb(1'b0, 6'h02, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    wr(IDX_CTRL_ONE, 32'h40);
    rd_chk(IDX_STATUS, 32'h20, "status");
    wr(IDX_DATA_HIGH, 32'h11);
    wr(IDX_DATA_HIGH, 32'h22);
    rd_chk(IDX_STATUS, 32'h20, "status");
    wr(IDX_DATA_LOW, 32'h3C);
    rd_chk(IDX_STATUS, 32'h00, "status");
    wr(IDX_DATA_LOW, 32'h99);
    wr(IDX_DATA_HIGH, 32'h77);
    link(16'h00A5, 8);
    check("miso", {16'h0, rx}, 32'h3C);
    rd_chk(IDX_STATUS, 32'hA0, "status");
    rd_chk(IDX_DATA_HIGH, 32'h0, "high");
    rd_chk(IDX_DATA_HIGH, 32'h0, "high");
    rd_chk(IDX_STATUS, 32'hA0, "status");
    rd_chk(IDX_DATA_LOW, 32'hA5, "low");
    rd_chk(IDX_STATUS, 32'h20, "status");
    link(16'h005A, 8);
    link(16'h00C3, 8);
    rd_chk(IDX_DATA_LOW, 32'h5A, "low");
    rd_chk(IDX_STATUS, 32'hA0, "status");
    rd_chk(IDX_DATA_LOW, 32'h5A, "low");
    rd_chk(IDX_STATUS, 32'hA0, "status");
    rd_chk(IDX_DATA_LOW, 32'hC3, "low");
    rd_chk(IDX_STATUS, 32'h20, "status");
    link(16'h0001, 8);
    link(16'h0002, 8);
    link(16'h0003, 8);
    apb(1'b0, IDX_STATUS, 32'h0);
    rd_chk(IDX_DATA_LOW, 32'h01, "low");
    apb(1'b0, IDX_STATUS, 32'h0);
    rd_chk(IDX_DATA_LOW, 32'h03, "low");
    apb(1'b0, IDX_STATUS, 32'h0);
    apb(1'b0, IDX_DATA_LOW, 32'h0);
    rd_chk(IDX_STATUS, 32'h20, "status");
    wr(IDX_CTRL_TWO, 32'h40);
    wr(IDX_DATA_WORD, 32'h1234);
    rd_chk(IDX_STATUS, 32'h00, "status");
    wr(IDX_DATA_WORD, 32'h5678);
    rd_chk(IDX_STATUS, 32'h00, "status");
    link(16'hBEEF, 16);
    check("miso", {16'h0, rx}, 32'h1234);
    wr(IDX_DATA_LOW, 32'h55);
    rd_chk(IDX_STATUS, 32'hA0, "status");
    rd_chk(IDX_DATA_LOW, 32'hEF, "low");
    rd_chk(IDX_DATA_HIGH, 32'h00, "high");
    rd_chk(IDX_STATUS, 32'h20, "status");
    wr(IDX_CTRL_TWO, 32'h00);
    wr(IDX_CTRL_ONE, 32'h50);
    wr(IDX_DATA_LOW, 32'h81);
    rd_chk(IDX_STATUS, 32'h20, "status");
    repeat (80) @(posedge pclk);
    rd_chk(IDX_STATUS, 32'hA0, "status");
    apb(1'b0, IDX_DATA_LOW, 32'h0);
    rd_chk(IDX_STATUS, 32'h20, "status");
    wr(IDX_CTRL_TWO, 32'h10);
    wr(IDX_CTRL_ONE, 32'hD0);
    far_u.select(1'b0);
    repeat (8) @(posedge pclk);
    check("irq", {31'h0, irq_req}, 32'h1);
    wr(IDX_CTRL_ONE, 32'hC0);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq_req}, 32'h1);
    rd_chk(IDX_STATUS, 32'h30, "status");
    wr(IDX_CTRL_ONE, 32'hC0);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq_req}, 32'h0);
    rd_chk(IDX_STATUS, 32'h20, "status");
    far_u.select(1'b1);
    repeat (8) @(posedge pclk);
    complete_run();
  end
endmodule

bind spi_status_data_regs spi_status_data_regs_checker chk_u (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .link_in(link_in), .link_out(link_out),
  .irq_req(irq_req));

`default_nettype wire
